// file: logic/flash_prot_pkg.sv
`default_nettype none
package flash_prot_pkg;

  // Address and protection-unit geometry
  localparam int ADDR_W = 26;
  localparam int DATA_W = 64;
  localparam int UNIT_W = 11;
  localparam int BLK_W = 10;
  localparam int BLK_LSB = 16;
  localparam int BLK256_W = 8;
  localparam int BLK256_LSB = 18;
  localparam int SEC_W = 5;
  localparam int SEC_LSB = 12;
  localparam int NUM_BLOCKS = 1024;
  localparam int PARAM_BLOCKS = 2;
  localparam int PARAM_SECTORS = 32;
  localparam int UNITS_64K = 1054;
  localparam int UNITS_256K = 256;
  localparam int BP_W = 4;

  // Register layouts and reset values
  localparam int SR_W = 6;
  localparam logic [SR_W-1:0] SR_RESET = 6'h00;
  localparam int PROTECTION_MODE_REGISTER_W = 16;
  localparam logic [PROTECTION_MODE_REGISTER_W-1:0] PROTECTION_MODE_REGISTER_RESET = 16'hFFFF;
  localparam int PWD_SEL_BIT = 2;
  localparam logic [DATA_W-1:0] PWD_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam int LOCK_REG_W = 8;
  localparam int LOCK_BIT_POS = 0;

  typedef enum logic [3:0] {
    OP_WRITE_ENABLE,
    OP_WRITE_DISABLE,
    OP_STATUS_WRITE,
    OP_PROGRAM,
    OP_ERASE,
    OP_PERS_PROG,
    OP_PERS_ERASE,
    OP_DYN_WRITE,
    OP_LOCK_CLEAR,
    OP_PWD_UNLOCK,
    OP_PWD_PROG,
    OP_MODE_PROG,
    OP_PWD_READ,
    OP_PERS_READ,
    OP_DYN_READ,
    OP_LOCK_READ
  } opcode_t;

  typedef struct packed {
    logic status_write_disable;
    logic quad_io_enable_bit;
    logic [BP_W-1:0] block_protect_bits;
  } sr_t;

  typedef struct packed {
    opcode_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic done;
    logic grant;
    logic refused;
    logic [DATA_W-1:0] rd_data;
  } resp_t;

endpackage
`default_nettype wire

// file: logic/prot_bit_mem.sv
`default_nettype none
module prot_bit_mem #(
  parameter int DEPTH = 1054,
  parameter int AW = 11
) (
  input wire logic clk_i,          // Clock
  input wire logic ce_i,           // Clock enable
  input wire logic fill_i,         // Set every bit to 1
  input wire logic wr_en_i,        // Single bit write
  input wire logic [AW-1:0] wr_addr_i, // Write index
  input wire logic wr_bit_i,       // Write value
  input wire logic [AW-1:0] rd_addr_i, // Read index
  output logic rd_bit_o            // Registered read bit
);

  logic [DEPTH-1:0] mem_ff;
  logic [DEPTH-1:0] nxt_mem;
  logic rd_ff;
  logic nxt_rd;

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("prot_bit_mem: DEPTH does not fit AW");
  end

  ////////////////////////////////////////////////////////////////////////
  // Fill wins over a single write; out-of-range indices read as 1
  always_comb begin
    nxt_mem = mem_ff;
    nxt_rd = rd_ff;
    if (ce_i) begin
      if (fill_i) begin
        nxt_mem = '1;
      end else if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
        nxt_mem[wr_addr_i] = wr_bit_i;
      end
      nxt_rd = (int'(rd_addr_i) < DEPTH) ? mem_ff[rd_addr_i] : 1'b1;
      if (fill_i) begin
        nxt_rd = 1'b1;
      end
    end
  end

  // Registers only; no reset so the array can outlive a reset
  always_ff @(posedge clk_i) begin
    mem_ff <= nxt_mem;
    rd_ff <= nxt_rd;
  end

  assign rd_bit_o = rd_ff;

endmodule // prot_bit_mem
`default_nettype wire

// file: logic/bp_decode.sv
`default_nettype none
module bp_decode #(
  parameter int NBLK = 1024,
  parameter int BW = 10
) (
  input wire logic [flash_prot_pkg::BP_W-1:0] bp_i, // Block-protect level
  input wire logic bottom_i,       // Protect from the bottom up
  input wire logic [BW-1:0] blk_i, // 64KB block index
  output logic hit_o               // Block is covered
);
  import flash_prot_pkg::*;

  logic [BW:0] span;

  if (NBLK > (1 << BW)) begin : g_chk
    $error("bp_decode: NBLK does not fit BW");
  end

  ////////////////////////////////////////////////////////////////////////
  // Level n covers 2**(n-1) blocks, saturating at the whole array
  always_comb begin
    span = '0;
    hit_o = 1'b0;
    if (bp_i != '0) begin
      if ((int'(bp_i) - 1) >= BW) begin
        span = (BW+1)'(NBLK);
      end else begin
        span = (BW+1)'(1) << (bp_i - 4'h1);
      end
      if (bottom_i) begin
        hit_o = {1'b0, blk_i} < span;
      end else begin
        hit_o = {1'b0, blk_i} >= ((BW+1)'(NBLK) - span);
      end
    end
  end

endmodule // bp_decode
`default_nettype wire

// file: logic/flash_write_protect.sv
`default_nettype none
// Operation
// RULE1 - Protect pin guards block-protect, write-disable and quad-enable status bits
// RULE2 - Status locked only when write-disable is 1 and protect pin low
// RULE3 - Program, erase and register writes need write-enable latch set first
// RULE4 - Four block-protect bits protect part or all of the array
// RULE5 - Unit is protected if block-protect or sector protection protects it
// RULE6 - Host should use block-protect or sector protection, not both
// RULE7 - 64KB mode adds 32 parameter sectors; 256KB mode has none
// RULE8 - Each unit has persistent and dynamic bit; either zero blocks writes
// RULE9 - Persistent bits cannot change while the lock bit is 0
// RULE10 - Persistent bits start erased so every unit is unprotected
// RULE11 - Persistent mode sets lock bit to 1 at reset
// RULE12 - Persistent mode: lock-clear drives lock to 0, nothing sets it
// RULE13 - Password mode clears lock bit to 0 at reset
// RULE14 - A hidden 64-bit password is held, programmable once
// RULE15 - Unlock with an exact password match sets the lock bit
// RULE16 - Password mode: lock-clear drops lock, later unlock may set it
// RULE17 - One-time bits of the mode register choose the lock management
// RULE18 - Password reads are blanked once password mode is chosen
// RULE19 - Lock bit is volatile at bit 0 of lock register
// RULE20 - A wrong password leaves the lock bit at 0
module flash_write_protect (
  input wire logic CLK_I,                      // 25 MHz clock
  input wire logic SRST_I,                     // Sync reset, high
  input wire logic CE_I,                       // Clock enable
  input wire logic FACTORY_FRESH_I,            // Reset loads shipped state
  input wire logic WP_N_I,                     // Protect pin, low active
  input wire logic BIG_BLOCK_I,                // Uniform 256KB blocks
  input wire logic PARAM_TOP_I,                // Parameter sectors on top
  input wire logic BP_BOTTOM_I,                // Block-protect from bottom
  input wire logic CMD_VALID_I,                // Command offered
  input wire flash_prot_pkg::cmd_t CMD_I,      // Command word
  output logic CMD_READY_O,                    // Command taken when high
  output flash_prot_pkg::resp_t RESP_O,        // Result of last command
  output flash_prot_pkg::sr_t STATUS_O,        // Status bits
  output logic WEL_O,                          // Write enable latch
  output logic [flash_prot_pkg::LOCK_REG_W-1:0] LOCK_REG_O, // Lock reg
  output logic PWD_MODE_O                      // Password mode chosen
);
  import flash_prot_pkg::*;

  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_LOOK, ST_EXEC} state_t;

  state_t st_ff, nxt_st;
  cmd_t cmd_ff, nxt_cmd;
  logic [UNIT_W-1:0] unit_ff, nxt_unit;
  sr_t sr_ff, nxt_sr;
  logic wel_ff, nxt_wel;
  logic lock_ff, nxt_lock;
  resp_t resp_ff, nxt_resp;
  logic [DATA_W-1:0] pwd_ff, nxt_pwd;
  logic [PROTECTION_MODE_REGISTER_W-1:0] protection_mode_register_ff, nxt_protection_mode_register;
  logic pwd_load, protection_mode_register_load;
  logic pers_wr, pers_fill, dyn_wr, dyn_bit;
  logic pers_rd, dyn_rd, bp_hit;
  logic pwd_mode, sr_locked, unit_prot, wr_type, take;

  ////////////////////////////////////////////////////////////////////////
  // Address to protection unit; parameter sectors get their own units
  function automatic logic [UNIT_W-1:0] unit_of(
    input logic [ADDR_W-1:0] a,
    input logic big,
    input logic top
  );
    logic [BLK_W-1:0] blk;
    logic [SEC_W-1:0] sec;
    logic [UNIT_W-1:0] u;
    blk = a[BLK_LSB +: BLK_W];
    sec = a[SEC_LSB +: SEC_W];
    if (big) begin
      u = UNIT_W'(a[BLK256_LSB +: BLK256_W]); // [RULE7]
    end else if (!top && (blk < BLK_W'(PARAM_BLOCKS))) begin
      u = UNIT_W'(sec); // [RULE7]
    end else if (!top) begin
      u = UNIT_W'(blk) + UNIT_W'(PARAM_SECTORS - PARAM_BLOCKS);
    end else if (blk < BLK_W'(NUM_BLOCKS - PARAM_BLOCKS)) begin
      u = UNIT_W'(blk);
    end else begin
      u = UNIT_W'(NUM_BLOCKS - PARAM_BLOCKS) + UNIT_W'(sec); // [RULE7]
    end
    return u;
  endfunction

  // Commands that the write enable latch must arm
  function automatic logic needs_wel(input opcode_t op);
    case (op)
      OP_STATUS_WRITE, OP_PROGRAM, OP_ERASE, OP_PERS_PROG, OP_PERS_ERASE,
      OP_DYN_WRITE, OP_LOCK_CLEAR, OP_PWD_PROG, OP_MODE_PROG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Protection bit arrays and block-protect decoder
  prot_bit_mem #(.DEPTH(UNITS_64K), .AW(UNIT_W)) u_pers_mem (
    .clk_i(CLK_I),
    .ce_i(CE_I || SRST_I),
    .fill_i(pers_fill),
    .wr_en_i(pers_wr),
    .wr_addr_i(unit_ff),
    .wr_bit_i(1'b0),
    .rd_addr_i(unit_ff),
    .rd_bit_o(pers_rd)
  );

  prot_bit_mem #(.DEPTH(UNITS_64K), .AW(UNIT_W)) u_dyn_mem (
    .clk_i(CLK_I),
    .ce_i(CE_I || SRST_I),
    .fill_i(SRST_I),
    .wr_en_i(dyn_wr),
    .wr_addr_i(unit_ff),
    .wr_bit_i(dyn_bit),
    .rd_addr_i(unit_ff),
    .rd_bit_o(dyn_rd)
  );

  bp_decode #(.NBLK(NUM_BLOCKS), .BW(BLK_W)) u_bp (
    .bp_i(sr_ff.block_protect_bits),
    .bottom_i(BP_BOTTOM_I),
    .blk_i(cmd_ff.addr[BLK_LSB +: BLK_W]),
    .hit_o(bp_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Protection terms
  assign pwd_mode = !protection_mode_register_ff[PWD_SEL_BIT]; // [RULE17]
  // Pin high makes the write-disable bit toothless
  assign sr_locked = sr_ff.status_write_disable && !WP_N_I; // [RULE1] [RULE2]
  // Both schemes OR together; using both is legal but discouraged
  assign unit_prot = bp_hit || !pers_rd || !dyn_rd; // [RULE4] [RULE5] [RULE8]
  assign wr_type = needs_wel(cmd_ff.op);
  assign CMD_READY_O = (st_ff == ST_IDLE) && CE_I;
  assign take = CMD_READY_O && CMD_VALID_I;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: take, look up unit bits, execute, report
  always_comb begin
    nxt_st = st_ff;
    nxt_cmd = cmd_ff;
    nxt_unit = unit_ff;
    nxt_sr = sr_ff;
    nxt_wel = wel_ff;
    nxt_lock = lock_ff;
    nxt_resp = resp_ff;
    pwd_load = 1'b0;
    protection_mode_register_load = 1'b0;
    pers_wr = 1'b0;
    pers_fill = SRST_I && FACTORY_FRESH_I; // [RULE10]
    dyn_wr = 1'b0;
    dyn_bit = cmd_ff.data[0];
    // Reset cuts a command in flight so no array write lands on its edge
    if (CE_I && !SRST_I) begin
      case (st_ff)
        ST_INIT: begin
          // Mode register is settled only after reset, so the lock
          // level is taken one cycle after release
          nxt_lock = !pwd_mode; // [RULE11] [RULE13]
          nxt_st = ST_IDLE;
        end
        ST_IDLE: begin
          nxt_resp.done = 1'b0;
          nxt_resp.grant = 1'b0;
          nxt_resp.refused = 1'b0;
          if (take) begin
            nxt_cmd = CMD_I;
            nxt_unit = unit_of(CMD_I.addr, BIG_BLOCK_I, PARAM_TOP_I);
            nxt_st = ST_LOOK;
          end
        end
        ST_LOOK: begin
          nxt_st = ST_EXEC;
        end
        ST_EXEC: begin
          nxt_st = ST_IDLE;
          nxt_resp.done = 1'b1;
          if (wr_type && !wel_ff) begin
            nxt_resp.refused = 1'b1; // [RULE3]
          end else begin
            case (cmd_ff.op)
              OP_WRITE_ENABLE: nxt_wel = 1'b1;
              OP_WRITE_DISABLE: nxt_wel = 1'b0;
              OP_STATUS_WRITE: begin
                if (sr_locked) begin
                  nxt_resp.refused = 1'b1; // [RULE1] [RULE2]
                end else begin
                  nxt_sr = sr_t'(cmd_ff.data[SR_W-1:0]);
                end
              end
              OP_PROGRAM, OP_ERASE: begin
                nxt_resp.grant = !unit_prot; // [RULE5] [RULE8]
                nxt_resp.refused = unit_prot;
              end
              OP_PERS_PROG: begin
                pers_wr = lock_ff; // [RULE9]
                nxt_resp.refused = !lock_ff;
              end
              OP_PERS_ERASE: begin
                pers_fill = lock_ff; // [RULE9]
                nxt_resp.refused = !lock_ff;
              end
              OP_DYN_WRITE: dyn_wr = 1'b1; // [RULE8]
              OP_LOCK_CLEAR: nxt_lock = 1'b0; // [RULE12] [RULE16]
              OP_PWD_UNLOCK: begin
                // Persistent mode has no way to raise the lock again
                if (pwd_mode && (cmd_ff.data == pwd_ff)) begin
                  nxt_lock = 1'b1; // [RULE15] [RULE16]
                end else begin
                  nxt_resp.refused = 1'b1; // [RULE20] [RULE12]
                end
              end
              OP_PWD_PROG: begin
                pwd_load = !pwd_mode; // [RULE14]
                nxt_resp.refused = pwd_mode;
              end
              OP_MODE_PROG: protection_mode_register_load = 1'b1; // [RULE17]
              OP_PWD_READ: begin
                nxt_resp.rd_data = pwd_mode ? '1 : pwd_ff; // [RULE18]
              end
              OP_PERS_READ: nxt_resp.rd_data = DATA_W'(pers_rd);
              OP_DYN_READ: nxt_resp.rd_data = DATA_W'(dyn_rd);
              OP_LOCK_READ: nxt_resp.rd_data = DATA_W'(LOCK_REG_O);
              default: ;
            endcase
          end
          // The latch drops after every write-type command, taken or not
          if (wr_type) begin
            nxt_wel = 1'b0; // [RULE3]
          end
        end
        default: nxt_st = ST_INIT;
      endcase
    end
  end

  // Control registers; lock is cleared here and set in ST_INIT
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_ff <= ST_INIT;
      cmd_ff <= '0;
      unit_ff <= '0;
      sr_ff <= sr_t'(SR_RESET);
      wel_ff <= 1'b0;
      lock_ff <= 1'b0; // [RULE19]
      resp_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cmd_ff <= nxt_cmd;
      unit_ff <= nxt_unit;
      sr_ff <= nxt_sr;
      wel_ff <= nxt_wel;
      lock_ff <= nxt_lock;
      resp_ff <= nxt_resp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-time bits only ever clear, so a choice cannot be undone
  always_comb begin
    nxt_pwd = pwd_ff;
    nxt_protection_mode_register = protection_mode_register_ff;
    if (pwd_load) begin
      nxt_pwd = pwd_ff & cmd_ff.data; // [RULE14]
    end
    if (protection_mode_register_load) begin
      nxt_protection_mode_register = protection_mode_register_ff & cmd_ff.data[PROTECTION_MODE_REGISTER_W-1:0]; // [RULE17]
    end
  end

  // Survives reset unless the shipped state is requested
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      if (FACTORY_FRESH_I) begin
        pwd_ff <= PWD_RESET;
        protection_mode_register_ff <= PROTECTION_MODE_REGISTER_RESET;
      end
    end else begin
      pwd_ff <= nxt_pwd;
      protection_mode_register_ff <= nxt_protection_mode_register;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    LOCK_REG_O = '0;
    LOCK_REG_O[LOCK_BIT_POS] = lock_ff; // [RULE19]
  end
  assign RESP_O = resp_ff;
  assign STATUS_O = sr_ff;
  assign WEL_O = wel_ff;
  assign PWD_MODE_O = pwd_mode;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_wel_gate: assert property ( // [RULE3]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && wr_type && !wel_ff)
      |=> (RESP_O.refused && !RESP_O.grant && !WEL_O))
    else $error("write-type command ran without the latch");

  chk_status_lock: assert property ( // [RULE2]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && cmd_ff.op == OP_STATUS_WRITE &&
     STATUS_O.status_write_disable && !WP_N_I)
      |=> ($stable(STATUS_O) && RESP_O.refused))
    else $error("status bits changed while pin-protected");

  chk_bp_guard: assert property ( // [RULE5]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && cmd_ff.op == OP_PROGRAM && bp_hit &&
     wel_ff) |=> (!RESP_O.grant && RESP_O.refused))
    else $error("program granted inside block-protect range");

  chk_bit_guard: assert property ( // [RULE8]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && cmd_ff.op == OP_ERASE &&
     (!pers_rd || !dyn_rd)) |=> !RESP_O.grant)
    else $error("erase granted on a unit with a zero bit");

  chk_pers_locked: assert property ( // [RULE9]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && cmd_ff.op == OP_PERS_PROG && !lock_ff)
      |-> (!pers_wr ##1 RESP_O.refused))
    else $error("persistent bit written while locked");

  chk_init_lock: assert property ( // [RULE11]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_INIT && CE_I) |=> (LOCK_REG_O[LOCK_BIT_POS] == !pwd_mode))
    else $error("lock level after reset wrong for mode");

  chk_pers_noset: assert property ( // [RULE12]
    @(posedge CLK_I) disable iff (SRST_I)
    (!pwd_mode && !lock_ff && st_ff != ST_INIT) |=> !lock_ff)
    else $error("lock rose in persistent mode");

  chk_unlock_ok: assert property ( // [RULE15]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && cmd_ff.op == OP_PWD_UNLOCK && pwd_mode &&
     cmd_ff.data == pwd_ff) |=> (lock_ff && RESP_O.done))
    else $error("matching password did not unlock");

  chk_bad_pwd: assert property ( // [RULE20]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && cmd_ff.op == OP_PWD_UNLOCK &&
     cmd_ff.data != pwd_ff && !lock_ff) |=> (!lock_ff [*2]))
    else $error("wrong password changed the lock");

  chk_pwd_hidden: assert property ( // [RULE18]
    @(posedge CLK_I) disable iff (SRST_I)
    (st_ff == ST_EXEC && CE_I && cmd_ff.op == OP_PWD_READ && pwd_mode)
      |=> (RESP_O.rd_data == '1))
    else $error("password visible in password mode");

endmodule // flash_write_protect
`default_nettype wire

// file: verification/host_model.sv
`default_nettype none
module host_model (
  input wire logic clk_i,                   // Clock
  input wire logic ready_i,                 // Command taken when high
  input wire flash_prot_pkg::resp_t resp_i, // Device answer
  output logic valid_o,                     // Command offered
  output flash_prot_pkg::cmd_t cmd_o        // Command word
);
  timeunit 1ns;
  timeprecision 100ps;
  import flash_prot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    valid_o = 1'b0;
    cmd_o = '0;
  end

  // Offer one command, hold it to the taking edge, then wait for done
  task automatic issue(input opcode_t op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output resp_t r);
    int n;
    @(posedge clk_i);
    #1;
    valid_o = 1'b1;
    cmd_o = '{op, a, d};
    n = 0;
    while (ready_i !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i);
    #1;
    valid_o = 1'b0;
    // Scrambled so a stale word can never pass for a fresh one
    cmd_o = ~cmd_o;
    n = 0;
    while (resp_i.done !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    r = resp_i;
  endtask
endmodule // host_model
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_prot_pkg::*;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic fresh = 1'b1;
  logic wp_n = 1'b1;
  logic big = 1'b0;
  logic ptop = 1'b0;
  logic bpbot = 1'b1;
  logic valid;
  cmd_t cmd;
  logic ready;
  resp_t resp;
  resp_t last;
  sr_t status;
  logic write_enable_latch;
  logic [LOCK_REG_W-1:0] lock_reg;
  logic pwd_mode;
  int mismatches = 0;
  int checks_done = 0;
  localparam logic [DATA_W-1:0] PW = 64'h1234_5678_9ABC_DEF0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #20 clk = ~clk;

  flash_write_protect u_flash_write_protect (
    .CLK_I(clk), .SRST_I(srst), .CE_I(ce), .FACTORY_FRESH_I(fresh),
    .WP_N_I(wp_n), .BIG_BLOCK_I(big), .PARAM_TOP_I(ptop),
    .BP_BOTTOM_I(bpbot), .CMD_VALID_I(valid), .CMD_I(cmd),
    .CMD_READY_O(ready), .RESP_O(resp), .STATUS_O(status), .WEL_O(write_enable_latch),
    .LOCK_REG_O(lock_reg), .PWD_MODE_O(pwd_mode));

  host_model u_host_model (
    .clk_i(clk), .ready_i(ready), .resp_i(resp), .valid_o(valid),
    .cmd_o(cmd));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and command helpers
  task automatic check1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check64(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Only program and erase report a grant; an x skips the verdict
  task automatic run(input opcode_t op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic g);
    u_host_model.issue(op, a, d, last);
    check1("done", 1'b1, last.done);
    if (g !== 1'bx) begin
      check1(op.name(), g && (op == OP_PROGRAM || op == OP_ERASE),
             last.grant);
      check1("refused", !g, last.refused);
    end
  endtask

  // Write-type commands are preceded by the enabling command
  task automatic wr(input opcode_t op, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d, input logic g);
    run(OP_WRITE_ENABLE, '0, '0, 1'b1);
    run(op, a, d, g);
  endtask

  task automatic do_reset(input logic f);
    @(posedge clk);
    #1;
    srst = 1'b1;
    fresh = f;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check64("lock_reg", 64'h1, 64'(lock_reg));
    check1("pwd_mode", 1'b0, pwd_mode);
    run(OP_PERS_READ, 26'h3FF_0000, '0, 1'b1);
    check1("pers_bit", 1'b1, last.rd_data[0]);
    run(OP_LOCK_READ, '0, '0, 1'b1);
    check64("lock_read", 64'h1, last.rd_data);
  endtask

  task automatic t_wel();
    run(OP_PROGRAM, 26'h010_0000, '0, 1'b0);
    run(OP_STATUS_WRITE, '0, 64'h3F, 1'b0);
    check64("status", 64'h0, 64'(status));
    run(OP_WRITE_ENABLE, '0, '0, 1'b1);
    check1("wel", 1'b1, write_enable_latch);
    // Frozen clock enable must hold the latch and block new commands
    ce = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check1("ready", 1'b0, ready);
    check1("wel", 1'b1, write_enable_latch);
    ce = 1'b1;
    run(OP_ERASE, 26'h010_0000, '0, 1'b1);
    check1("wel", 1'b0, write_enable_latch);
    run(OP_WRITE_ENABLE, '0, '0, 1'b1);
    run(OP_WRITE_DISABLE, '0, '0, 1'b1);
    check1("wel", 1'b0, write_enable_latch);
  endtask

  // All four pin and disable-bit pairs; quad and block-protect bits are the probe
  task automatic t_status();
    logic p;
    for (int i = 0; i < 4; i++) begin
      p = i[1] && !i[0];
      wp_n = 1'b1;
      wr(OP_STATUS_WRITE, '0, 64'(i[1]) << 5, 1'b1);
      wp_n = i[0];
      wr(OP_STATUS_WRITE, '0, (64'(i[1]) << 5) | 64'h1F, !p);
      check64("status", p ? 64'(i[1]) << 5 : (64'(i[1]) << 5) | 64'h1F,
              64'(status));
    end
    wp_n = 1'b1;
    wr(OP_STATUS_WRITE, '0, '0, 1'b1);
  endtask

  task automatic t_bp();
    wr(OP_STATUS_WRITE, '0, 64'h1, 1'b1);
    wr(OP_PROGRAM, 26'h000_0000, '0, 1'b0);
    wr(OP_ERASE, 26'h001_0000, '0, 1'b1);
    wr(OP_DYN_WRITE, 26'h005_0000, '0, 1'b1);
    wr(OP_ERASE, 26'h005_0000, '0, 1'b0);
    wr(OP_PROGRAM, 26'h006_0000, '0, 1'b1);
    wr(OP_STATUS_WRITE, '0, 64'hF, 1'b1);
    wr(OP_PROGRAM, 26'h3FF_0000, '0, 1'b0);
    bpbot = 1'b0;
    wr(OP_STATUS_WRITE, '0, 64'h1, 1'b1);
    wr(OP_PROGRAM, 26'h3FF_0000, '0, 1'b0);
    wr(OP_PROGRAM, 26'h000_0000, '0, 1'b1);
    // Block-protect off, so later scenarios use sector protection alone
    wr(OP_STATUS_WRITE, '0, '0, 1'b1);
    wr(OP_DYN_WRITE, 26'h005_0000, 64'h1, 1'b1);
    wr(OP_PROGRAM, 26'h005_0000, '0, 1'b1);
  endtask

  task automatic t_param();
    wr(OP_DYN_WRITE, 26'h000_1000, '0, 1'b1);
    run(OP_DYN_READ, 26'h000_1000, '0, 1'b1);
    check1("dyn_bit", 1'b0, last.rd_data[0]);
    wr(OP_PROGRAM, 26'h000_0000, '0, 1'b1);
    wr(OP_PROGRAM, 26'h000_1000, '0, 1'b0);
    wr(OP_PROGRAM, 26'h000_2000, '0, 1'b1);
    big = 1'b1;
    wr(OP_PROGRAM, 26'h004_0000, '0, 1'b0);
    wr(OP_PROGRAM, 26'h000_1000, '0, 1'b1);
    big = 1'b0;
    ptop = 1'b1;
    wr(OP_DYN_WRITE, 26'h3FF_1000, '0, 1'b1);
    wr(OP_PROGRAM, 26'h3FF_0000, '0, 1'b1);
    wr(OP_PROGRAM, 26'h3FF_1000, '0, 1'b0);
    ptop = 1'b0;
  endtask

  task automatic t_persist();
    wr(OP_PERS_PROG, 26'h007_0000, '0, 1'b1);
    wr(OP_PROGRAM, 26'h007_0000, '0, 1'b0);
    wr(OP_LOCK_CLEAR, '0, '0, 1'b1);
    check1("lock", 1'b0, lock_reg[0]);
    wr(OP_PERS_ERASE, '0, '0, 1'b0);
    run(OP_PWD_UNLOCK, '0, '1, 1'b0);
    check1("lock", 1'b0, lock_reg[0]);
    do_reset(1'b0);
    check1("lock", 1'b1, lock_reg[0]);
    run(OP_PERS_READ, 26'h007_0000, '0, 1'b1);
    check1("pers_bit", 1'b0, last.rd_data[0]);
    wr(OP_PERS_ERASE, '0, '0, 1'b1);
    wr(OP_PROGRAM, 26'h007_0000, '0, 1'b1);
  endtask

  task automatic t_pwd();
    run(OP_PWD_READ, '0, '0, 1'b1);
    check64("pwd", '1, last.rd_data);
    wr(OP_PWD_PROG, '0, PW, 1'b1);
    run(OP_PWD_READ, '0, '0, 1'b1);
    check64("pwd", PW, last.rd_data);
    wr(OP_MODE_PROG, '0, 64'hFFFB, 1'b1);
    check1("pwd_mode", 1'b1, pwd_mode);
    do_reset(1'b0);
    check1("lock", 1'b0, lock_reg[0]);
    run(OP_PWD_READ, '0, '0, 1'b1);
    check64("pwd", '1, last.rd_data);
    wr(OP_PWD_PROG, '0, '0, 1'b0);
    wr(OP_MODE_PROG, '0, 64'hFFFF, 1'b1);
    check1("pwd_mode", 1'b1, pwd_mode);
    wr(OP_PERS_PROG, 26'h007_0000, '0, 1'b0);
    run(OP_PWD_UNLOCK, '0, PW ^ 64'h1, 1'b0);
    check1("lock", 1'b0, lock_reg[0]);
    run(OP_PWD_UNLOCK, '0, PW, 1'b1);
    check1("lock", 1'b1, lock_reg[0]);
    wr(OP_LOCK_CLEAR, '0, '0, 1'b1);
    check1("lock", 1'b0, lock_reg[0]);
    run(OP_PWD_UNLOCK, '0, PW, 1'b1);
    check1("lock", 1'b1, lock_reg[0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic summarize();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs under 500 cycles; this is a hundred times that
  initial begin
    #2_000_000;
    mismatches++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_wel();
    t_status();
    t_bp();
    t_param();
    t_persist();
    t_pwd();
    summarize();
  end
endmodule // testbench
`default_nettype wire
